// [hdl/qpc_defs.svh]
/*
 Register offsets, field positions, masks, reset values and response codes
 of the quadrature position counter. Assumes inclusion by bare name.
*/
`ifndef QPC_DEFS_SVH
`define QPC_DEFS_SVH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define QPC_ADDR_CTRL 5'h00
`define QPC_ADDR_POSH 5'h04
`define QPC_ADDR_POSL 5'h08
`define QPC_ADDR_HOLD 5'h0C
`define QPC_ADDR_CFG 5'h10

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
`define QPC_CCM_LSB 0
`define QPC_EXTERNAL_GATE_ENABLE_BIT 2
`define QPC_POL_BIT 3
`define QPC_DIV_LSB 4
`define QPC_PIM_LSB 8
`define QPC_CTRL_MASK 16'h07FF

// ------------------------------------------------------------
// Phase configuration fields
// ------------------------------------------------------------
`define QPC_IMV_LSB 0
`define QPC_SWAP_BIT 2
`define QPC_APOL_BIT 3
`define QPC_BPOL_BIT 4
`define QPC_CFG_MASK 16'h001F

`define QPC_RESET_WORD 16'h0000
`define QPC_RESP_OKAY 2'h0
`define QPC_RESP_SLVERR 2'h2

`endif

// [hdl/qpc_pkg.sv]
/*
 Types of the quadrature position counter.
 Assumes the defs header is compiled with it.
*/
package qpc_pkg;
   typedef enum logic [1:0] {
      QPC_MODE_QUAD,
      QPC_MODE_EXT_DIR,
      QPC_MODE_EXT_CLK,
      QPC_MODE_TIMER
   } qpc_mode_type;
endpackage : qpc_pkg

// [hdl/qpc_prescaler.sv]
/*
 Power-of-two prescaler producing a one-cycle count enable.
 Assumes a synchronous active-high reset and one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module qpc_prescaler
   import qpc_pkg::*;
#(
   parameter int DIV_W = 3
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [DIV_W-1:0] divSel,
   output logic tick
);
   logic [(1<<DIV_W)-1:0] count_q;
   logic [(1<<DIV_W)-1:0] limit;

   // [RULE_01] Divide by two to the code
   assign limit = ((1 << DIV_W)'(1) << divSel) - 1'b1;

   always_ff @(posedge ref_clk) begin
      if (reset || count_q >= limit) begin
         count_q <= '0;
      end else begin
         count_q <= count_q + 1'b1;
      end
   end

   // Code 000 gives an enable every cycle
   assign tick = (count_q >= limit);
endmodule : qpc_prescaler
`default_nettype wire

// [hdl/qpc_counter.sv]
/*
 Quadrature position counter with AXI4-Lite register slave.
 Assumes encoder inputs already synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "qpc_defs.svh"

// Function
// [RULE_01] The 3-bit prescale code divides the counter clock 1:1 to 1:128.
// [RULE_02] Polarity 0 counts positive unless the up/down input reverses it.
// [RULE_03] With gate enable set the gate input controls counting, else none.
// [RULE_04] Mode 11 timer, 10 and 01 external clock, 00 quadrature x4.
// [RULE_05] Modes 10 and 11 run as timers and ignore position init mode.
// [RULE_06] In mode 00 phases equal to the index match value clear the count.
// [RULE_07] Swap and polarity apply to the phases before the index match.
// [RULE_08] Software keeps the counter rate at twice the quadrature rate.
// [RULE_09] Two 16-bit words form the 32-bit count, cleared at reset.
// [RULE_10] A 16-bit hold register carries the high word for software.
// [RULE_11] Low read latches high into hold; low write loads high from hold.
// [RULE_12] Quadrature x4 steps on every phase edge with decoded direction.
module qpc_counter
   import qpc_pkg::*;
#(
   parameter int CNT_W = 32,
   parameter int DIV_W = 3
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic phaseA,
   input wire logic phaseB,
   input wire logic extUpDown,
   input wire logic extGate,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [CNT_W-1:0] positionCount
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [15:0] ctrl_q;
   logic [15:0] cfg_q;
   logic [15:0] hold_q;
   logic [CNT_W-1:0] pos_q;
   logic phA_q;
   logic phB_q;
   logic [4:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic awHave_q;
   logic wHave_q;

   qpc_mode_type mode;
   logic tick;
   logic gateOk;
   logic phA;
   logic phB;
   logic edgeSeen;
   logic dirUp;
   logic upDown;
   logic idxMatch;
   logic doWrite;
   logic doRead;

   // Byte-lane merge, used for every writable word
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] st);
      merge16 = old;
      if (st[0]) begin
         merge16[7:0] = wd[7:0];
      end
      if (st[1]) begin
         merge16[15:8] = wd[15:8];
      end
   endfunction : merge16

   assign mode = qpc_mode_type'(ctrl_q[`QPC_CCM_LSB +: 2]);

   // ------------------------------------------------------------
   // Count enable and phase decode
   // ------------------------------------------------------------
   qpc_prescaler #(
      .DIV_W(DIV_W)
   ) u_prescaler (
      .ref_clk(ref_clk),
      .reset(reset),
      .divSel(ctrl_q[`QPC_DIV_LSB +: DIV_W]),
      .tick(tick)
   );

   // [RULE_03] Gate qualifies counting
   assign gateOk = !ctrl_q[`QPC_EXTERNAL_GATE_ENABLE_BIT] || extGate;

   // [RULE_07] Swap then polarity
   assign phA = (cfg_q[`QPC_SWAP_BIT] ? phaseB : phaseA)
                ^ cfg_q[`QPC_APOL_BIT];
   assign phB = (cfg_q[`QPC_SWAP_BIT] ? phaseA : phaseB)
                ^ cfg_q[`QPC_BPOL_BIT];

   // [RULE_06] Index match on conditioned phases
   assign idxMatch = ({phB, phA} == cfg_q[`QPC_IMV_LSB +: 2]);

   // [RULE_12] Edge on either phase, direction from order
   assign edgeSeen = (phA != phA_q) || (phB != phB_q);
   assign dirUp = (phA_q ^ phB);

   // [RULE_02] Polarity reverses the up/down sense
   assign upDown = extUpDown ^ ctrl_q[`QPC_POL_BIT];

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         phA_q <= 1'b0;
         phB_q <= 1'b0;
      end else begin
         phA_q <= phA;
         phB_q <= phB;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite handshake
   // ------------------------------------------------------------
   assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
   assign doRead = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         awHave_q <= 1'b0;
         awAddr_q <= '0;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHave_q <= 1'b1;
         awAddr_q <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (doWrite) begin
         awHave_q <= 1'b0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !awHave_q && !s_axi_bvalid && !s_axi_awready;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wHave_q <= 1'b0;
         wData_q <= '0;
         wStrb_q <= '0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHave_q <= 1'b1;
         wData_q <= s_axi_wdata;
         wStrb_q <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (doWrite) begin
         wHave_q <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !wHave_q && !s_axi_bvalid && !s_axi_wready;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `QPC_RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         case (awAddr_q)
            `QPC_ADDR_CTRL, `QPC_ADDR_POSH, `QPC_ADDR_POSL,
            `QPC_ADDR_HOLD, `QPC_ADDR_CFG: begin
               s_axi_bresp <= `QPC_RESP_OKAY;
            end
            default: begin
               s_axi_bresp <= `QPC_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Control and phase configuration words
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_q <= `QPC_RESET_WORD;
      end else if (doWrite && awAddr_q == `QPC_ADDR_CTRL) begin
         ctrl_q <= merge16(ctrl_q, wData_q, wStrb_q) & `QPC_CTRL_MASK;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cfg_q <= `QPC_RESET_WORD;
      end else if (doWrite && awAddr_q == `QPC_ADDR_CFG) begin
         cfg_q <= merge16(cfg_q, wData_q, wStrb_q) & `QPC_CFG_MASK;
      end
   end

   // ------------------------------------------------------------
   // Hold register
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         hold_q <= `QPC_RESET_WORD;
      // [RULE_11] Low read snapshots high word
      end else if (doRead && s_axi_araddr == `QPC_ADDR_POSL) begin
         hold_q <= pos_q[31:16];
      // [RULE_10] Software access to hold
      end else if (doWrite && awAddr_q == `QPC_ADDR_HOLD) begin
         hold_q <= merge16(hold_q, wData_q, wStrb_q);
      end
   end

   // ------------------------------------------------------------
   // Position counter; software writes win over counting
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      // [RULE_09] Cleared at reset
      if (reset) begin
         pos_q <= '0;
      end else if (doWrite && awAddr_q == `QPC_ADDR_POSH) begin
         pos_q[31:16] <= merge16(pos_q[31:16], wData_q, wStrb_q);
      end else if (doWrite && awAddr_q == `QPC_ADDR_POSL) begin
         // [RULE_11] Low write commits hold to high
         pos_q[15:0] <= merge16(pos_q[15:0], wData_q, wStrb_q);
         pos_q[31:16] <= hold_q;
      end else begin
         // [RULE_04] Mode select
         case (mode)
            QPC_MODE_QUAD: begin
               // [RULE_06] Index match clears both words
               if (idxMatch && gateOk) begin
                  pos_q <= '0;
               // [RULE_12] x4 step per edge
               end else if (edgeSeen && gateOk) begin
                  pos_q <= dirUp ? pos_q + 1'b1 : pos_q - 1'b1;
               end
            end
            QPC_MODE_EXT_DIR: begin
               // [RULE_02] Counts on phase A rise, sense set by up/down
               if (phA && !phA_q && gateOk) begin
                  pos_q <= upDown ? pos_q - 1'b1 : pos_q + 1'b1;
               end
            end
            QPC_MODE_EXT_CLK: begin
               // [RULE_05] Timer counting, init mode ignored
               if (phA && !phA_q && gateOk) begin
                  pos_q <= pos_q + 1'b1;
               end
            end
            QPC_MODE_TIMER: begin
               // [RULE_01] Prescaled internal clock
               if (tick && gateOk) begin
                  pos_q <= pos_q + 1'b1;
               end
            end
            default: begin
               pos_q <= pos_q;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Read data path
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= `QPC_RESP_OKAY;
      end else if (doRead) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `QPC_RESP_OKAY;
         case (s_axi_araddr)
            `QPC_ADDR_CTRL: s_axi_rdata <= {16'h0000, ctrl_q};
            `QPC_ADDR_POSH: s_axi_rdata <= {16'h0000, pos_q[31:16]};
            `QPC_ADDR_POSL: s_axi_rdata <= {16'h0000, pos_q[15:0]};
            `QPC_ADDR_HOLD: s_axi_rdata <= {16'h0000, hold_q};
            `QPC_ADDR_CFG: s_axi_rdata <= {16'h0000, cfg_q};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `QPC_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         // One read in flight keeps the hold snapshot unambiguous
         s_axi_arready <= !s_axi_arready;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         positionCount <= '0;
      end else begin
         positionCount <= pos_q;
      end
   end
endmodule : qpc_counter
`default_nettype wire

// [verif/qpc_counter_assertions.sv]
/*
 Port checker of the quadrature position counter.
 Assumes binding to qpc_counter, one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module qpc_counter_assertions
#(
   parameter int CNT_W = 32,
   parameter int DIV_W = 3
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [CNT_W-1:0] positionCount
);
   // ---------------------------------------------------------
   // Bus answers and counter reset
   // ---------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   chk_bresp_stands: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_rdata_stands: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   chk_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_read_cause: assert property (
      $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
      else $error("read answer without request");
   // Answer comes two edges after the later of the two handshakes
   chk_write_cause: assert property (
      $rose(s_axi_bvalid) |->
         $past(s_axi_awvalid && s_axi_awready, 2) ||
         $past(s_axi_wvalid && s_axi_wready, 2))
      else $error("write answer without request");
   chk_write_quiet: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   chk_upper_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   chk_reset_clear: assert property (
      $fell(reset) |-> positionCount == '0 && !s_axi_bvalid && !s_axi_rvalid)
      else $error("state not cleared by reset");
endmodule : qpc_counter_assertions

bind qpc_counter qpc_counter_assertions #(.CNT_W(CNT_W), .DIV_W(DIV_W))
   qpc_counter_assertions_inst (.ref_clk, .reset, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .positionCount);
`default_nettype wire

// [verif/qpc_encoder_model.sv]
/*
 Behavioural quadrature encoder driving both phase lines.
 Assumes the bench calls step from its own sequence.
*/
`timescale 1ns/1ps
`default_nettype none
module qpc_encoder_model (
   input wire logic ref_clk,
   output logic phaseA,
   output logic phaseB
);
   // ---------------------------------------------------------
   // Gray sequence 00,01,11,10 counts up, B leading
   // ---------------------------------------------------------
   logic [1:0] grayState_q = 2'h0;
   assign phaseA = grayState_q[1];
   assign phaseB = grayState_q[1] ^ grayState_q[0];
   task automatic step(input logic up);
      @(posedge ref_clk);
      grayState_q <= up ? grayState_q + 2'h1 : grayState_q - 2'h1;
      repeat (4) @(posedge ref_clk);
   endtask : step
endmodule : qpc_encoder_model
`default_nettype wire

// [verif/quadrature_position_counter_bench.sv]
/*
 Self-checking bench of the quadrature position counter.
 Assumes the design, its defs header and the encoder model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "qpc_defs.svh"
module quadrature_position_counter_bench;
   // ---------------------------------------------------------
   // Stimulus and instances
   // ---------------------------------------------------------
   logic ref_clk = 1'b0, reset = 1'b1, extUpDown = 1'b0, extGate = 1'b0;
   logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, phaseA, phaseB;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [31:0] s_axi_rdata, positionCount, rd;
   int failCount = 0, samplesChecked = 0;

   always #4 ref_clk = ~ref_clk;

   qpc_counter qpc_counter_inst (.ref_clk, .reset, .phaseA, .phaseB,
      .extUpDown, .extGate, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .positionCount);
   qpc_encoder_model qpc_encoder_model_inst (.ref_clk, .phaseA, .phaseB);

   task automatic printVerdict;
      $display("checked %0d, wrong %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : printVerdict

   task automatic chk(input string nm, input logic [31:0] e, g);
      samplesChecked++;
      if (g !== e) begin
         failCount++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge ref_clk);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 64) begin
         failCount++;
         printVerdict();
      end
      @(posedge ref_clk);
   endtask : wr

   task automatic rdt(input logic [4:0] a);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge ref_clk);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 64) begin
         failCount++;
         printVerdict();
      end
      @(posedge ref_clk);
   endtask : rdt

   task automatic rdc(input string nm, input logic [4:0] a, logic [15:0] e);
      rdt(a);
      chk(nm, {16'h0000, e}, rd);
   endtask : rdc

   task automatic setp(input logic [31:0] v);
      wr(`QPC_ADDR_HOLD, v[31:16]);
      wr(`QPC_ADDR_POSL, v[15:0]);
   endtask : setp

   // Counter output lags the register by one cycle
   task automatic pc(input logic [31:0] e);
      repeat (3) @(posedge ref_clk);
      chk("positionCount", e, positionCount);
   endtask : pc

   task automatic pulse(input int n);
      repeat (n) begin
         qpc_encoder_model_inst.step(1'b0);
         qpc_encoder_model_inst.step(1'b1);
      end
   endtask : pulse

   // Tick phase is unknown, so one count either way is allowed
   task automatic rate(input int d, input int e);
      logic [31:0] p;
      repeat (3) @(posedge ref_clk);
      p = positionCount;
      repeat (d) @(posedge ref_clk);
      p = positionCount - p;
      chk("tickInRange", 32'h1, {31'h0, p + 32'h1 >= 32'(e) &&
         p <= 32'(e) + 32'h1});
   endtask : rate

   initial begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      for (int i = 0; i < 5; i++)
         rdc("resetWord", 5'(4 * i), 16'h0000);
      $display("test reset values done");
      wr(`QPC_ADDR_CTRL, 16'h0001);
      setp(32'h12345678);
      rdc("highWord", `QPC_ADDR_POSH, 16'h1234);
      chk("positionCount", 32'h12345678, positionCount);
      wr(`QPC_ADDR_POSH, 16'hABCD);
      rdc("lowWord", `QPC_ADDR_POSL, 16'h5678);
      rdc("holdWord", `QPC_ADDR_HOLD, 16'hABCD);
      // Low byte lane only; upper byte must keep its value
      s_axi_wstrb <= 4'h1;
      wr(`QPC_ADDR_HOLD, 16'h5511);
      s_axi_wstrb <= 4'hF;
      rdc("holdLowLane", `QPC_ADDR_HOLD, 16'hAB11);
      $display("test word pairing done");
      setp(32'h00000000);
      pulse(3);
      pc(32'h00000003);
      extUpDown <= 1'b1;
      pulse(1);
      pc(32'h00000002);
      wr(`QPC_ADDR_CTRL, 16'h0009);
      extUpDown <= 1'b0;
      pulse(1);
      pc(32'h00000001);
      extUpDown <= 1'b1;
      pulse(1);
      pc(32'h00000002);
      wr(`QPC_ADDR_CTRL, 16'h0002);
      extUpDown <= 1'b0;
      pulse(2);
      pc(32'h00000004);
      $display("test external clock done");
      wr(`QPC_ADDR_CTRL, 16'h0000);
      pc(32'h00000000);
      for (int i = 1; i < 4; i++) begin
         qpc_encoder_model_inst.step(1'b1);
         pc(32'(i));
      end
      qpc_encoder_model_inst.step(1'b1);
      pc(32'h00000000);
      qpc_encoder_model_inst.step(1'b0);
      pc(32'hFFFFFFFF);
      wr(`QPC_ADDR_CFG, 16'h0006);
      pc(32'h00000000);
      // Unswapping moves both phases at once: one down step
      wr(`QPC_ADDR_CFG, 16'h0000);
      pc(32'hFFFFFFFF);
      qpc_encoder_model_inst.step(1'b0);
      pc(32'hFFFFFFFE);
      wr(`QPC_ADDR_CFG, 16'h0018);
      pc(32'h00000000);
      $display("test quadrature done");
      for (int k = 0; k < 8; k++) begin
         wr(`QPC_ADDR_CTRL, 16'(3 + 16 * k));
         rate(512, 512 >> k);
      end
      wr(`QPC_ADDR_CTRL, 16'h0007);
      rate(64, 0);
      extGate <= 1'b1;
      rate(64, 64);
      $display("test timer and gate done");
      wr(5'h14, 16'hFFFF);
      chk("writeResp", 32'(`QPC_RESP_SLVERR), 32'(rs));
      rdt(5'h14);
      chk("readResp", 32'(`QPC_RESP_SLVERR), 32'(rs));
      chk("unmappedData", 32'h00000000, rd);
      $display("test unmapped done");
      printVerdict();
   end
endmodule : quadrature_position_counter_bench
`default_nettype wire
